// ===== bench/sfmc_controller_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfmc_map.svh"
module sfmc_controller_asserts (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	logic flagRd_ff;
	// remember which register the pending answer belongs to
	always_ff @(posedge clk_sys) begin
		if (s_axi_arvalid && s_axi_arready)
			flagRd_ff <= (s_axi_araddr == `SFMC_OFF_FLAGS);
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_full_msb: assert property (s_axi_rvalid && flagRd_ff
		&& s_axi_rdata[0] |-> s_axi_rdata[5]) else $error("msb without full");
	a_ovr_sticky: assert property (s_axi_rvalid && flagRd_ff
		&& s_axi_rdata[6] |-> s_axi_rdata[3]) else $error("live w/o sticky");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("bvalid dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_rd_lat: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read latency");
	a_wr_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
		else $error("write latency");
	a_aw_block: assert property (s_axi_bvalid && s_axi_awvalid
		&& s_axi_awready |=> !s_axi_awready) else $error("accepts during b");
	a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("accepts during r");
	c_flags: cover property (s_axi_rvalid && flagRd_ff && s_axi_rdata[0]);
	c_ovr: cover property (s_axi_rvalid && flagRd_ff && s_axi_rdata[6]);
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind sfmc_controller sfmc_controller_asserts chk_u (.clk_sys, .rst_n,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// ===== bench/sfmc_controller_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfmc_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("CHECK FAILED %0t %h %h", $time, (a), (b)); end end
module sfmc_controller_tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0;
	logic sampleValid;
	logic [31:0] sampleData;
	logic [4:0] eventIrq = 5'h0;
	logic awv = 0, awr, wv = 0, wr_, bv, br = 0, arv = 0, arr, rv, rr = 0;
	logic [7:0] awa = 8'h0, ara = 8'h0;
	logic [31:0] wd = 32'h0, rd_;
	logic [1:0] bresp, rresp;
	logic [31:0] d;
	logic [1:0] r;
	int bad_count = 0, total_checks = 0, cyc = 0;
	always #12.5 clk_sys = ~clk_sys;
	sfmc_sample_src src_u (.clk_sys(clk_sys), .sampleValid(sampleValid),
		.sampleData(sampleData));
	sfmc_controller dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.sampleValid(sampleValid), .sampleData(sampleData),
		.eventIrq(eventIrq), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .s_axi_rdata(rd_), .s_axi_rresp(rresp));
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// handshakes judged on values sampled at the rising edge itself
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic tb;
		@(posedge clk_sys);
		{awa, wd, awv, wv, br} <= {a, v, 3'b111};
		do begin
			@(posedge clk_sys);
			tb = bv;
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_) wv <= 1'b0;
		end while (!tb);
		br <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic tr;
		@(posedge clk_sys);
		{ara, arv, rr} <= {a, 2'b11};
		do begin
			@(posedge clk_sys);
			tr = rv;
			if (tr) begin
				d = rd_;
				r = rresp;
			end
			if (arv && arr) arv <= 1'b0;
		end while (!tr);
		rr <= 1'b0;
	endtask
	task automatic clear_all();
		wr(`SFMC_OFF_MODE, 32'h0);
		wr(`SFMC_OFF_LIMIT, 32'h0);
	endtask
	task automatic t_reset();
		rd(`SFMC_OFF_THRESHOLD); `CHK(d, 32'h0)
		rd(8'hFC); `CHK(r, 2'h2)
	endtask
	task automatic t_stop();
		wr(`SFMC_OFF_MODE, 32'h1);
		src_u.send(260, 32'h100);
		rd(`SFMC_OFF_COUNT_LOW); `CHK(d, 32'h0)
		rd(`SFMC_OFF_FLAGS); `CHK(d & 32'h21, 32'h21)
		rd(`SFMC_OFF_DATA); `CHK(d, 32'h100)
	endtask
	task automatic t_bypass();
		clear_all();
		src_u.send(4, 32'h0);
		rd(`SFMC_OFF_COUNT_LOW); `CHK(d, 32'h0)
		rd(`SFMC_OFF_FLAGS); `CHK(d & 32'h69, 32'h0)
	endtask
	task automatic t_cont();
		wr(`SFMC_OFF_MODE, 32'h6);
		src_u.send(258, 32'h2000);
		rd(`SFMC_OFF_FLAGS); `CHK(d & 32'h69, 32'h69)
		rd(`SFMC_OFF_DATA); `CHK(d, 32'h2002)
		rd(`SFMC_OFF_FLAGS); `CHK(d & 32'h48, 32'h08)
		clear_all();
	endtask
	task automatic t_limit();
		wr(`SFMC_OFF_THRESHOLD, 32'hA);
		wr(`SFMC_OFF_LIMIT, 32'h1);
		wr(`SFMC_OFF_MODE, 32'h1);
		src_u.send(20, 32'h0);
		rd(`SFMC_OFF_COUNT_LOW); `CHK(d, 32'hA)
		rd(`SFMC_OFF_FLAGS); `CHK(d & 32'hA1, 32'hA0)
		clear_all();
		wr(`SFMC_OFF_THRESHOLD, 32'h0);
	endtask
	task automatic pulse(input logic [4:0] e);
		@(posedge clk_sys) eventIrq <= e;
		repeat (4) @(posedge clk_sys);
		eventIrq <= 5'h0;
	endtask
	task automatic t_c2s();
		wr(`SFMC_OFF_ROUTING, 32'h1);
		wr(`SFMC_OFF_MODE, 32'h3);
		src_u.send(300, 32'h0);
		pulse(5'h1);
		src_u.send(2, 32'h500);
		rd(`SFMC_OFF_FLAGS); `CHK(d & 32'h21, 32'h21)
		rd(`SFMC_OFF_DATA); `CHK(d, 32'h2C)
		clear_all();
	endtask
	task automatic t_b2c();
		wr(`SFMC_OFF_ROUTING, 32'h10);
		wr(`SFMC_OFF_MODE, 32'h4);
		pulse(5'h1);
		src_u.send(3, 32'h0);
		rd(`SFMC_OFF_COUNT_LOW); `CHK(d, 32'h0)
		pulse(5'h10);
		src_u.send(3, 32'h700);
		rd(`SFMC_OFF_COUNT_LOW); `CHK(d, 32'h3)
		rd(`SFMC_OFF_DATA); `CHK(d, 32'h700)
	endtask
	// generous ceiling: the longest runs push about 300 words
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc > 40000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_stop();
		t_bypass();
		t_cont();
		t_limit();
		t_c2s();
		t_b2c();
		test_done();
	end
endmodule
`default_nettype wire

// ===== bench/sfmc_sample_src.sv
`timescale 1ns/100ps
`default_nettype none
module sfmc_sample_src (
	// clock
	input wire logic        clk_sys,
	// sample stream
	output logic            sampleValid,
	output logic [31:0]     sampleData
);
	initial begin
		sampleValid = 1'b0;
		sampleData = 32'h0;
	end
	// one word every other cycle; data inverted while idle so nothing stale
	task automatic send(input int n, input logic [31:0] base);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			sampleValid <= 1'b1;
			sampleData <= base + i;
			@(posedge clk_sys);
			sampleValid <= 1'b0;
			sampleData <= ~(base + i);
		end
	endtask
endmodule
`default_nettype wire

// ===== rtl/sfmc_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfmc_map.svh"
module sfmc_controller (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// sensor batching source
	input  wire logic        sampleValid,
	input  wire logic [31:0] sampleData,
	// motion event detectors: tap, double tap, fall, wake, orientation
	input  wire logic [4:0]  eventIrq,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// axi4-lite write data and response
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	import sfmc_pkg::*;

	localparam int DEPTH = `SFMC_DEPTH;
	localparam logic [8:0] FULL_CNT = 9'(`SFMC_DEPTH);
	localparam logic [8:0] PRE_FULL = 9'(`SFMC_DEPTH - 1);

	sfmc_store_if st();
	sfmc_store #(.DEPTH(DEPTH), .W(`SFMC_DATA_W)) uStore (
		.clk_sys (clk_sys),
		.st      (st)
	);

	// register state
	logic [7:0]  thr_ff, nxt_thr;
	logic        stopThr_ff, nxt_stopThr;
	sfmc_mode_t  mode_ff, nxt_mode;
	logic [4:0]  route_ff, nxt_route;
	// buffer state
	sfmc_op_t    op_ff, nxt_op;
	logic [7:0]  wrIdx_ff, nxt_wrIdx;
	logic [7:0]  rdIdx_ff, nxt_rdIdx;
	logic [8:0]  cnt_ff, nxt_cnt;
	logic        trig_ff, nxt_trig;
	logic        stopReq_ff, nxt_stopReq;
	logic        evPrev_ff, nxt_evPrev;
	logic        full_ff, nxt_full;
	logic        ovr_ff, nxt_ovr;
	logic        ovrL_ff, nxt_ovrL;
	// bus state
	logic        awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
	logic [7:0]  awAddr_ff, nxt_awAddr;
	logic [31:0] wData_ff, nxt_wData;
	logic        wLow_ff, nxt_wLow;
	logic        bValid_ff, nxt_bValid, rValid_ff, nxt_rValid;
	logic        arRdy_ff, nxt_arRdy;
	logic [31:0] rData_ff, nxt_rData;
	logic [1:0]  bResp_ff, nxt_bResp, rResp_ff, nxt_rResp;

	function automatic logic known(input logic [7:0] a);
		known = (a == `SFMC_OFF_THRESHOLD) || (a == `SFMC_OFF_LIMIT) ||
			(a == `SFMC_OFF_MODE) || (a == `SFMC_OFF_ROUTING) ||
			(a == `SFMC_OFF_COUNT_LOW) || (a == `SFMC_OFF_FLAGS) ||
			(a == `SFMC_OFF_DATA);
	endfunction

	logic        doWr, doRd, modeWr, popWord, evEdge, store, limitHit;
	logic [8:0]  cap, cntAfter;
	logic [7:0]  flags;
	sfmc_mode_t  wMode;

	always_comb begin
		// bus handshake; write taken once both halves held
		nxt_awHeld = awHeld_ff;
		nxt_wHeld  = wHeld_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wData  = wData_ff;
		nxt_wLow   = wLow_ff;
		if (s_axi_awvalid && !awHeld_ff) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !wHeld_ff) begin
			nxt_wHeld = 1'b1;
			nxt_wData = s_axi_wdata;
			nxt_wLow  = s_axi_wstrb[0];
		end
		doWr = awHeld_ff && wHeld_ff && !bValid_ff;
		nxt_bValid = bValid_ff;
		nxt_bResp  = bResp_ff;
		if (doWr) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld  = 1'b0;
			nxt_bValid = 1'b1;
			nxt_bResp  = known(awAddr_ff) ? 2'h0 : 2'h2;
		end else if (bValid_ff && s_axi_bready) begin
			nxt_bValid = 1'b0;
		end
		doRd = s_axi_arvalid && arRdy_ff;
		nxt_arRdy = !doRd && !(rValid_ff && !s_axi_rready);
		nxt_rValid = doRd ? 1'b1 : (rValid_ff && !s_axi_rready);
		nxt_rData = rData_ff;
		nxt_rResp = rResp_ff;
		// only the low byte lane carries register bits
		modeWr = doWr && wLow_ff && (awAddr_ff == `SFMC_OFF_MODE);
		wMode  = sfmc_mode_t'(wData_ff[2:0]);
		nxt_thr = (doWr && wLow_ff && awAddr_ff == `SFMC_OFF_THRESHOLD) ?
			wData_ff[7:0] : thr_ff;
		nxt_stopThr = (doWr && wLow_ff && awAddr_ff == `SFMC_OFF_LIMIT) ?
			wData_ff[0] : stopThr_ff;
		nxt_route = (doWr && wLow_ff && awAddr_ff == `SFMC_OFF_ROUTING) ?
			wData_ff[4:0] : route_ff;
		nxt_mode = modeWr ? wMode : mode_ff;

		// buffer
		popWord = doRd && (s_axi_araddr == `SFMC_OFF_DATA) && cnt_ff != 9'h000;
		// threshold of zero leaves the limit at full depth
		cap = (stopThr_ff && thr_ff != 8'h00) ? {1'b0, thr_ff} : FULL_CNT;
		nxt_evPrev = |(eventIrq & route_ff);
		evEdge = nxt_evPrev && !evPrev_ff && !trig_ff;
		nxt_trig = trig_ff || evEdge;
		nxt_op = op_ff;
		nxt_stopReq = stopReq_ff;
		nxt_wrIdx = wrIdx_ff;
		nxt_rdIdx = popWord ? rdIdx_ff + 8'h01 : rdIdx_ff;
		nxt_cnt = popWord ? cnt_ff - 9'h001 : cnt_ff;
		nxt_ovr = ovr_ff && !popWord;
		nxt_ovrL = ovrL_ff;
		store = 1'b0;
		limitHit = cnt_ff >= cap;
		case (op_ff)
		SFMC_OP_IDLE: begin
			if (mode_ff == SFMC_STOP_FULL || mode_ff == SFMC_CONT_STOP) begin
				nxt_op = (mode_ff == SFMC_STOP_FULL) ? SFMC_OP_FILL : SFMC_OP_WRAP;
			end else if (mode_ff == SFMC_CONTINUOUS) begin
				nxt_op = SFMC_OP_WRAP;
			end else if (mode_ff == SFMC_BYP_CONT && evEdge) begin
				nxt_op = SFMC_OP_WRAP;
			end
		end
		SFMC_OP_FILL: begin
			// stop: full means no more words
			store = sampleValid && !limitHit;
		end
		SFMC_OP_WRAP: begin
			if (mode_ff == SFMC_CONT_STOP && evEdge) begin
				if (limitHit) begin
					nxt_stopReq = 1'b1;
				end else begin
					nxt_op = SFMC_OP_FILL;
				end
			end
			if (stopReq_ff && sampleValid) begin
				nxt_op = SFMC_OP_FILL;
				nxt_stopReq = 1'b0;
			end else begin
				store = sampleValid;
			end
		end
		default: nxt_op = SFMC_OP_IDLE;
		endcase
		if (store) begin
			nxt_wrIdx = wrIdx_ff + 8'h01;
			if (limitHit && !popWord) begin
				// overwrite oldest word
				nxt_rdIdx = rdIdx_ff + 8'h01;
				nxt_ovr = 1'b1;
				nxt_ovrL = 1'b1;
			end else begin
				nxt_cnt = nxt_cnt + 9'h001;
			end
			// limited size wraps inside the threshold window
			if (stopThr_ff && thr_ff != 8'h00 && wrIdx_ff == thr_ff - 8'h01) begin
				nxt_wrIdx = 8'h00;
			end
		end
		cntAfter = nxt_cnt;
		// full warns one write ahead at 255 of 256; under a limit it sets on reaching the limit
		nxt_full = (op_ff != SFMC_OP_IDLE || nxt_op != SFMC_OP_IDLE) &&
			(cap == FULL_CNT ? cntAfter >= PRE_FULL : cntAfter >= cap);
		if (modeWr && wMode == SFMC_BYPASS) begin
			// clear pointers, count, full, overrun and stop request, and re-arm the trigger
			nxt_op = SFMC_OP_IDLE;
			nxt_wrIdx = 8'h00;
			nxt_rdIdx = 8'h00;
			nxt_cnt = 9'h000;
			nxt_trig = 1'b0;
			nxt_stopReq = 1'b0;
			nxt_full = 1'b0;
			nxt_ovr = 1'b0;
			nxt_ovrL = 1'b0;
		end else if (modeWr) begin
			nxt_op = SFMC_OP_IDLE;
		end
		if (mode_ff == SFMC_BYPASS) begin
			nxt_cnt = 9'h000;
			store = 1'b0;
		end
		st.wrEn = store && mode_ff != SFMC_BYPASS;
		st.wrIdx = wrIdx_ff;
		st.wrData = sampleData;
		st.rdIdx = rdIdx_ff;
		flags = 8'h00;
		flags[`SFMC_FLAG_WTM] = cnt_ff >= {1'b0, thr_ff};
		flags[`SFMC_FLAG_OVR] = ovr_ff;
		flags[`SFMC_FLAG_FULL] = full_ff;
		flags[`SFMC_FLAG_OVRL] = ovrL_ff;
		flags[`SFMC_FLAG_MSB] = cnt_ff[8];
		if (doRd) begin
			nxt_rResp = known(s_axi_araddr) ? 2'h0 : 2'h2;
			case (s_axi_araddr)
			`SFMC_OFF_THRESHOLD: nxt_rData = {24'h000000, thr_ff};
			`SFMC_OFF_LIMIT:     nxt_rData = {31'h00000000, stopThr_ff};
			`SFMC_OFF_MODE:      nxt_rData = {29'h00000000, mode_ff};
			`SFMC_OFF_ROUTING:   nxt_rData = {27'h0000000, route_ff};
			`SFMC_OFF_COUNT_LOW: nxt_rData = {24'h000000, cnt_ff[7:0]};
			`SFMC_OFF_FLAGS:     nxt_rData = {24'h000000, flags};
			`SFMC_OFF_DATA:      nxt_rData = (cnt_ff != 9'h000) ?
				st.rdData : 32'h00000000;
			default:             nxt_rData = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			thr_ff <= `SFMC_THR_RESET;
			stopThr_ff <= 1'b0;
			mode_ff <= SFMC_BYPASS;
			route_ff <= 5'h00;
			op_ff <= SFMC_OP_IDLE;
			wrIdx_ff <= 8'h00;
			rdIdx_ff <= 8'h00;
			cnt_ff <= 9'h000;
			trig_ff <= 1'b0;
			stopReq_ff <= 1'b0;
			evPrev_ff <= 1'b0;
			full_ff <= 1'b0;
			ovr_ff <= 1'b0;
			ovrL_ff <= 1'b0;
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h00000000;
			wLow_ff <= 1'b0;
			bValid_ff <= 1'b0;
			rValid_ff <= 1'b0;
			arRdy_ff <= 1'b0;
			rData_ff <= 32'h00000000;
			bResp_ff <= 2'h0;
			rResp_ff <= 2'h0;
		end else begin
			thr_ff <= nxt_thr;
			stopThr_ff <= nxt_stopThr;
			mode_ff <= nxt_mode;
			route_ff <= nxt_route;
			op_ff <= nxt_op;
			wrIdx_ff <= nxt_wrIdx;
			rdIdx_ff <= nxt_rdIdx;
			cnt_ff <= nxt_cnt;
			trig_ff <= nxt_trig;
			stopReq_ff <= nxt_stopReq;
			evPrev_ff <= nxt_evPrev;
			full_ff <= nxt_full;
			ovr_ff <= nxt_ovr;
			ovrL_ff <= nxt_ovrL;
			awHeld_ff <= nxt_awHeld;
			wHeld_ff <= nxt_wHeld;
			awAddr_ff <= nxt_awAddr;
			wData_ff <= nxt_wData;
			wLow_ff <= nxt_wLow;
			bValid_ff <= nxt_bValid;
			rValid_ff <= nxt_rValid;
			arRdy_ff <= nxt_arRdy;
			rData_ff <= nxt_rData;
			bResp_ff <= nxt_bResp;
			rResp_ff <= nxt_rResp;
		end
	end

	// all outputs straight from flip-flops
	assign s_axi_awready = !awHeld_ff;
	assign s_axi_wready  = !wHeld_ff;
	assign s_axi_bvalid  = bValid_ff;
	assign s_axi_bresp   = bResp_ff;
	assign s_axi_arready = arRdy_ff;
	assign s_axi_rvalid  = rValid_ff;
	assign s_axi_rdata   = rData_ff;
	assign s_axi_rresp   = rResp_ff;
endmodule
`default_nettype wire

// ===== rtl/sfmc_map.svh
// Function
// - bypass clears buffer and keeps it empty
// - mode 001 stores until full, then holds
// - nine-bit count kept; full sets msb, stops
// - watermark flag when count reaches threshold
// - stop-at-threshold limits size, raises full
// - full flag one write before 256 words
// - continuous mode wraps, overwrites oldest words
// - continuous full flag when next write fills
// - live and sticky overrun flags
// - mode 011 continuous then stop on trigger
// - trigger is routed tap, double tap, fall, wake, orientation
// - rising edge switches once until bypass
// - full at trigger stops at next sample
// - not full at trigger fills then stops
// - continuous-to-stop full flag at next write
// - mode 100 bypass then continuous on trigger
// - after switch, full flag at next write
`ifndef SFMC_MAP_SVH
`define SFMC_MAP_SVH
`define SFMC_OFF_THRESHOLD   8'h00
`define SFMC_OFF_LIMIT       8'h04
`define SFMC_OFF_MODE        8'h08
`define SFMC_OFF_ROUTING     8'h0C
`define SFMC_OFF_COUNT_LOW   8'h10
`define SFMC_OFF_FLAGS       8'h14
`define SFMC_OFF_DATA        8'h18
`define SFMC_DEPTH           256
`define SFMC_CNT_W           9
`define SFMC_DATA_W          32
`define SFMC_THR_RESET       8'h00
`define SFMC_MODE_W          3
`define SFMC_ROUTE_W         5
`define SFMC_FLAG_WTM        7
`define SFMC_FLAG_OVR        6
`define SFMC_FLAG_FULL       5
`define SFMC_FLAG_OVRL       3
`define SFMC_FLAG_MSB        0
`endif

// ===== rtl/sfmc_pkg.sv
package sfmc_pkg;
	typedef enum logic [2:0] {
		SFMC_BYPASS      = 3'h0,
		SFMC_STOP_FULL   = 3'h1,
		SFMC_CONT_STOP   = 3'h3,
		SFMC_BYP_CONT    = 3'h4,
		SFMC_CONTINUOUS  = 3'h6
	} sfmc_mode_t;
	typedef enum logic [1:0] {
		SFMC_OP_IDLE,
		SFMC_OP_FILL,
		SFMC_OP_WRAP
	} sfmc_op_t;
endpackage

// ===== rtl/sfmc_store.sv
`timescale 1ns/100ps
`default_nettype none
module sfmc_store #(
	parameter int DEPTH = 256,
	parameter int W     = 32
) (
	// clock
	input wire logic clk_sys,
	// storage port
	sfmc_store_if.mem st
);
	logic [W-1:0] mem [DEPTH];
	// flip-flop array, no reset: content is gated by the count
	always_ff @(posedge clk_sys) begin
		if (st.wrEn) begin
			mem[st.wrIdx] <= st.wrData;
		end
	end
	assign st.rdData = mem[st.rdIdx];
endmodule
`default_nettype wire

// ===== rtl/sfmc_store_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sfmc_store_if;
	logic        wrEn;
	logic [7:0]  wrIdx;
	logic [31:0] wrData;
	logic [7:0]  rdIdx;
	logic [31:0] rdData;
	modport ctrl (output wrEn, output wrIdx, output wrData, output rdIdx,
		input rdData);
	modport mem (input wrEn, input wrIdx, input wrData, input rdIdx,
		output rdData);
endinterface
`default_nettype wire
